//--- logic/dpm_pin_sync.sv
/*
  Three-stage pin synchroniser for a bundle of bits.
  Assumes inputs are asynchronous to clk; a bit changes only once the
  second and third stages agree.
*/
module dpm_pin_sync #(
  parameter int W = 10
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Pins in, stable copy out
  input  wire logic [W-1:0] pin_in,
  output logic      [W-1:0] pin_out
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] val;
  } dpm_sync_t;

  dpm_sync_t st_q;
  dpm_sync_t st_d;

  // Stage one feeds only stage two; disagreement holds the old value
  always_comb begin
    st_d     = st_q;
    st_d.s1  = pin_in;
    st_d.s2  = st_q.s1;
    st_d.s3  = st_q.s2;
    st_d.val = (st_q.s2 & ~(st_q.s2 ^ st_q.s3)) |
               (st_q.val & (st_q.s2 ^ st_q.s3));
  end

  // Idle bus is high, so reset to all ones
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '1;
    end else begin
      st_q <= st_d;
    end
  end

  assign pin_out = st_q.val;

endmodule // dpm_pin_sync

//--- logic/dpm_pkg.sv
/*
  Constants and carrier types for the display power mode command block:
  opcodes, register offsets, field positions, reset values, wake timing.
  Assumes a 250 MHz core clock and byte-wide command writes from a host.
*/
package dpm_pkg;

  // Command opcodes
  localparam logic [7:0] OP_SLEEP_ENTRY = 8'h10;
  localparam logic [7:0] OP_WAKE        = 8'h11;
  localparam logic [7:0] OP_PARTIAL_ON  = 8'h12;
  localparam logic [7:0] OP_FULL_ON     = 8'h13;

  // Register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_DIAG   = 8'h08;

  // Control register fields
  localparam int CTRL_SCROLL_BIT = 0;
  localparam int CTRL_FAULT_BIT  = 1;
  localparam logic [1:0] CTRL_RESET = 2'h0;

  // Diagnostic result fields
  localparam int DIAG_LOAD_BIT  = 7;
  localparam int DIAG_FUNC_BIT  = 6;
  localparam int DIAG_CSUM_BIT  = 0;
  localparam logic [7:0] DIAG_RESET = 8'h00;

  // Timing: figures in their own unit, counts derived from the clock
  localparam int CLK_KHZ     = 250000;
  localparam int SETTLE_MS   = 5;
  localparam int SETTLE_CYC  = SETTLE_MS * CLK_KHZ;
  localparam int OSC_US      = 100;
  localparam int OSC_CYC     = OSC_US * CLK_KHZ / 1000;
  localparam int CONV_US     = 500;
  localparam int CONV_CYC    = CONV_US * CLK_KHZ / 1000;
  localparam int CHARGE_US   = 1000;
  localparam int CHARGE_CYC  = CHARGE_US * CLK_KHZ / 1000;
  localparam int FRAME_CYC   = 4000;
  localparam int BLANK_FRAMES = 2;
  localparam int TIMER_W     = 21;

  // Display mode flags
  typedef struct packed {
    logic sleep;
    logic partial;
    logic scroll;
    logic normal;
  } dpm_mode_t;

  localparam dpm_mode_t MODE_RESET = 4'h9;

  // Power and panel drive state
  typedef struct packed {
    logic osc;
    logic conv;
    logic scan;
    logic blank;
  } dpm_power_t;

  localparam dpm_power_t POWER_RESET = 4'h0;

  // Command bus pins as sampled
  typedef struct packed {
    logic       dcs;
    logic       wr_n;
    logic [7:0] data;
  } dpm_pins_t;

endpackage

//--- logic/dpm_power_modes.sv
/*
  Display power mode command interpreter: decodes wake, sleep-entry,
  partial and normal commands from the display command bus, runs the
  timed wake sequence and keeps the mode flags and diagnostic result.
  Assumes a host on the pins that honours the settle and sleep gaps,
  and a register master on the plain port with one-cycle strobes.
*/
module dpm_power_modes #(
  parameter int SETTLE_CYC = dpm_pkg::SETTLE_CYC,
  parameter int OSC_CYC    = dpm_pkg::OSC_CYC,
  parameter int CONV_CYC   = dpm_pkg::CONV_CYC,
  parameter int CHARGE_CYC = dpm_pkg::CHARGE_CYC,
  parameter int FRAME_CYC  = dpm_pkg::FRAME_CYC
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst_n,
  // Display command bus pins
  input  wire logic              data_command_select,
  input  wire logic              write_strobe_n,
  input  wire logic [7:0]        cmd_data,
  // Register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic      [31:0]       reg_rdata,
  // Mode and power state
  output dpm_pkg::dpm_mode_t     mode,
  output dpm_pkg::dpm_power_t    power,
  output logic                   load_defaults,
  output logic                   settle_busy
);

  localparam int TW = dpm_pkg::TIMER_W;

  typedef enum logic [2:0] {
    ST_SLEEP,
    ST_OSC,
    ST_CONV,
    ST_CHARGE,
    ST_BLANK,
    ST_SHOW
  } dpm_state_t;

  typedef struct packed {
    dpm_state_t          fsm;
    dpm_pkg::dpm_mode_t  mode;
    dpm_pkg::dpm_power_t pwr;
    logic                wr_n_prev;
    logic                load_pls;
    logic                busy;
    logic [1:0]          ctrl;
    logic [7:0]          diag;
    logic [31:0]         rdata;
  } dpm_st_t;

  dpm_st_t            st_q;
  dpm_st_t            st_d;
  dpm_pkg::dpm_pins_t pins;
  logic               cmd_take;
  logic               data_take;
  logic               phase_load;
  logic [TW-1:0]      phase_val;
  logic               phase_done;
  logic               settle_done;
  logic               settle_load;

  // Pins come from the host's domain
  dpm_pin_sync #(
    .W (10)
  ) u_sync (
    .clk     (clk),
    .rst_n   (rst_n),
    .pin_in  ({data_command_select, write_strobe_n, cmd_data}),
    .pin_out (pins)
  );

  // Sequence step timer
  dpm_timer #(
    .W (TW)
  ) u_phase (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (phase_load),
    .load_val (phase_val),
    .done     (phase_done)
  );

  // Settle window timer
  dpm_timer #(
    .W (TW)
  ) u_settle (
    .clk      (clk),
    .rst_n    (rst_n),
    .load     (settle_load),
    .load_val (TW'(SETTLE_CYC)),
    .done     (settle_done)
  );

  // Write is taken on the rising strobe; select splits command from data
  assign cmd_take  = pins.wr_n & ~st_q.wr_n_prev & ~pins.dcs;
  assign data_take = pins.wr_n & ~st_q.wr_n_prev & pins.dcs;

  // Next state of the whole block
  always_comb begin
    st_d           = st_q;
    st_d.wr_n_prev = pins.wr_n;
    st_d.load_pls  = 1'b0;
    st_d.rdata     = 32'h0000_0000;
    phase_load     = 1'b0;
    phase_val      = TW'(OSC_CYC);
    settle_load    = 1'b0;

    // Wake sequence stepping, one step per timer expiry
    if (phase_done) begin
      case (st_q.fsm)
        ST_OSC: begin
          st_d.fsm   = ST_CONV;
          phase_load = 1'b1;
          phase_val  = TW'(CONV_CYC);
        end
        ST_CONV: begin
          st_d.fsm   = ST_CHARGE;
          phase_load = 1'b1;
          phase_val  = TW'(CHARGE_CYC);
        end
        ST_CHARGE: begin
          st_d.fsm   = ST_BLANK;
          phase_load = 1'b1;
          phase_val  = TW'(dpm_pkg::BLANK_FRAMES * FRAME_CYC);
        end
        ST_BLANK: begin
          st_d.fsm = ST_SHOW;
        end
        default: begin
          st_d.fsm = st_q.fsm;
        end
      endcase
    end

    // Accepted in every mode, asleep included
    if (cmd_take) begin
      case (pins.data)
        dpm_pkg::OP_WAKE: begin
          // Reload and diagnose on every wake; sequence only from sleep
          st_d.load_pls = 1'b1;
          st_d.busy     = 1'b1;
          settle_load   = 1'b1;
          if (st_q.fsm == ST_SLEEP) begin
            st_d.fsm        = ST_OSC;
            st_d.mode.sleep = 1'b0;
            phase_load      = 1'b1;
            phase_val       = TW'(OSC_CYC);
          end
        end
        dpm_pkg::OP_SLEEP_ENTRY: begin
          // Only exit from awake; already asleep is a no-op
          st_d.fsm        = ST_SLEEP;
          st_d.mode.sleep = 1'b1;
        end
        dpm_pkg::OP_PARTIAL_ON: begin
          if (!st_q.mode.partial) begin
            st_d.mode.partial = 1'b1;
            st_d.mode.normal  = 1'b0;
          end
        end
        dpm_pkg::OP_FULL_ON: begin
          if (!st_q.mode.normal) begin
            st_d.mode.partial = 1'b0;
            st_d.mode.scroll  = 1'b0;
            st_d.mode.normal  = 1'b1;
          end
        end
        default: begin
          st_d.fsm = st_d.fsm;
        end
      endcase
    end

    // Diagnosis finishes as the settle window closes
    if (settle_done) begin
      st_d.busy = settle_load; // A wake in the same cycle wins
      st_d.diag[dpm_pkg::DIAG_LOAD_BIT] =
        ~st_q.diag[dpm_pkg::DIAG_LOAD_BIT];
      st_d.diag[dpm_pkg::DIAG_FUNC_BIT] =
        st_q.diag[dpm_pkg::DIAG_FUNC_BIT] ^
        ~st_q.ctrl[dpm_pkg::CTRL_FAULT_BIT];
      st_d.diag[dpm_pkg::DIAG_CSUM_BIT] =
        st_q.ctrl[dpm_pkg::CTRL_FAULT_BIT];
    end

    // Register writes; scroll has no command here, so software sets it
    if (reg_wr && reg_addr == dpm_pkg::ADDR_CTRL) begin
      st_d.ctrl = reg_wdata[1:0];
      if (reg_wdata[dpm_pkg::CTRL_SCROLL_BIT]) begin
        st_d.mode.scroll = 1'b1;
        st_d.mode.normal = 1'b0;
      end
    end

    // Register reads; unmapped offsets answer zero
    if (reg_rd) begin
      case (reg_addr)
        dpm_pkg::ADDR_CTRL: begin
          st_d.rdata = {30'h0000_0000, st_q.ctrl};
        end
        dpm_pkg::ADDR_STATUS: begin
          st_d.rdata = {23'h00_0000, st_q.busy, st_q.mode,
                        st_q.pwr};
        end
        dpm_pkg::ADDR_DIAG: begin
          st_d.rdata = {24'h00_0000, st_q.diag};
        end
        default: begin
          st_d.rdata = 32'h0000_0000;
        end
      endcase
    end

    // Power outputs follow the next phase so they line up with it
    st_d.pwr.osc   = (st_d.fsm != ST_SLEEP);
    st_d.pwr.conv  = (st_d.fsm != ST_SLEEP) &&
                     (st_d.fsm != ST_OSC);
    st_d.pwr.scan  = (st_d.fsm == ST_BLANK) ||
                     (st_d.fsm == ST_SHOW);
    st_d.pwr.blank = (st_d.fsm != ST_SHOW);
  end

  // One register for all state
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q       <= '0;
      st_q.fsm   <= ST_SLEEP;
      st_q.mode  <= dpm_pkg::MODE_RESET;
      st_q.pwr   <= dpm_pkg::POWER_RESET;
      st_q.ctrl  <= dpm_pkg::CTRL_RESET;
      st_q.diag  <= dpm_pkg::DIAG_RESET;
      st_q.wr_n_prev <= 1'b1;
    end else begin
      st_q <= st_d;
    end
  end

  assign reg_rdata     = st_q.rdata;
  assign mode          = st_q.mode;
  assign power         = st_q.pwr;
  assign load_defaults = st_q.load_pls;
  assign settle_busy   = st_q.busy;

  // Counts blanking cycles for the frame check
  logic [TW-1:0] blank_cnt;
  always_ff @(posedge clk) begin
    if (!rst_n || st_q.fsm != ST_BLANK) begin
      blank_cnt <= '0;
    end else begin
      blank_cnt <= blank_cnt + 1'b1;
    end
  end

  chk_wake_from_sleep: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_WAKE && st_q.fsm == ST_SLEEP
    |=> st_q.fsm == ST_OSC && !mode.sleep && power.osc && !power.conv)
    else $error("wake from sleep did not start the oscillator");

  chk_awake_supplies: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_q.fsm == ST_SHOW |-> power.osc && power.conv && power.scan
    && !power.blank)
    else $error("awake without converter, oscillator or scan");

  chk_sequence_order: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_q.fsm == ST_CHARGE |=> st_q.fsm inside {ST_CHARGE, ST_BLANK,
    ST_SLEEP})
    else $error("panel charge not followed by blanking");

  chk_blank_frames: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_q.fsm == ST_BLANK ##1 st_q.fsm == ST_SHOW
    |-> $past(blank_cnt) == TW'(dpm_pkg::BLANK_FRAMES * FRAME_CYC - 1))
    else $error("blanking did not last two frames");

  chk_only_sleep_exits: assert property (
    @(posedge clk) disable iff (!rst_n)
    st_q.fsm != ST_SLEEP &&
    !(cmd_take && pins.data == dpm_pkg::OP_SLEEP_ENTRY)
    |=> st_q.fsm != ST_SLEEP)
    else $error("awake state left without sleep entry");

  chk_defaults_load: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_WAKE
    |=> load_defaults ##1 !load_defaults)
    else $error("defaults not loaded after wake");

  chk_diag_window: assert property (
    @(posedge clk) disable iff (!rst_n)
    $rose(settle_busy) |-> settle_busy[*8])
    else $error("settle window closed too soon");

  chk_rewake_quiet: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_WAKE && st_q.fsm == ST_SHOW
    |=> st_q.fsm == ST_SHOW && !power.blank)
    else $error("wake while awake disturbed the image");

  chk_partial_enter: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_PARTIAL_ON
    |=> mode.partial && !mode.normal)
    else $error("partial command did not enter partial mode");

  chk_normal_clears: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_FULL_ON && !reg_wr
    |=> mode.normal && !mode.partial && !mode.scroll)
    else $error("normal command left partial or scroll set");

  chk_data_ignored: assert property (
    @(posedge clk) disable iff (!rst_n)
    data_take && !reg_wr && !phase_done && !settle_done
    |=> $stable(mode) && $stable(st_q.fsm))
    else $error("data byte changed the mode");

  chk_sleep_power_off: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_SLEEP_ENTRY
    |=> mode.sleep && !power.osc && !power.conv && !power.scan)
    else $error("sleep entry left supplies running");

  chk_wake_busy_set: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_WAKE |=> settle_busy)
    else $error("settle window not running after wake");

  chk_partial_repeat: assert property (
    @(posedge clk) disable iff (!rst_n)
    cmd_take && pins.data == dpm_pkg::OP_PARTIAL_ON && mode.partial
    && !reg_wr |=> $stable(mode))
    else $error("repeated partial command changed the mode");

endmodule // dpm_power_modes

//--- logic/dpm_timer.sv
/*
  Load-and-count-down interval timer with a one-cycle done pulse.
  Assumes the loader gives a value of at least one.
*/
module dpm_timer #(
  parameter int W = 21
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Control
  input  wire logic         load,
  input  wire logic [W-1:0] load_val,
  // Status
  output logic              done
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } dpm_timer_t;

  dpm_timer_t st_q;
  dpm_timer_t st_d;

  // A reload restarts the interval, even mid-count
  always_comb begin
    st_d      = st_q;
    st_d.done = 1'b0;
    if (load) begin
      st_d.cnt  = load_val - 1'b1; // Interval is exactly load_val cycles
      st_d.done = (load_val == W'(1));
    end else if (st_q.cnt != '0) begin
      st_d.cnt  = st_q.cnt - 1'b1;
      st_d.done = (st_q.cnt == W'(1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign done = st_q.done;

endmodule // dpm_timer

//--- verification/dpm_host_model.sv
/*
  Host model that drives the display command bus pins byte by byte.
  Assumes the bench calls send(), which itself waits out the settle and sleep gaps.
*/
module dpm_host_model #(
  parameter int WAKE_GAP  = 210,
  parameter int SLEEP_GAP = 4800
) (
  // Clock
  input  wire logic       clk,
  // Command bus pins
  output logic            data_command_select,
  output logic            write_strobe_n,
  output logic      [7:0] cmd_data
);
  timeunit 1ns;
  timeprecision 100ps;

  int unsigned cyc_q    = 0;
  int unsigned ready_at = 0;

  // Free cycle count for the host gaps
  always @(posedge clk) cyc_q <= cyc_q + 1;

  // Idle pins: select high, data not left at the last byte
  initial begin
    data_command_select = 1'b1;
    write_strobe_n      = 1'b1;
    cmd_data            = 8'h5A;
  end

  // One byte, each strobe level held six cycles for the synchroniser
  task automatic send(input logic [7:0] b, input logic dc);
    while (cyc_q < ready_at) @(posedge clk);
    @(posedge clk);
    data_command_select <= dc;
    cmd_data            <= b;
    write_strobe_n      <= 1'b0;
    repeat (6) @(posedge clk);
    write_strobe_n <= 1'b1;  // Single byte, no parameters
    repeat (6) @(posedge clk);
    data_command_select <= 1'b1;
    cmd_data            <= ~b;
    if (!dc && b === dpm_pkg::OP_WAKE) ready_at = cyc_q + WAKE_GAP;
    if (!dc && b === dpm_pkg::OP_SLEEP_ENTRY) begin
      ready_at = cyc_q + SLEEP_GAP;
    end
  endtask
endmodule // dpm_host_model

//--- verification/dpm_power_modes_test.sv
/*
  Self-checking bench for the display power mode command block.
  Assumes short timing parameters and the host model on the pins.
*/
module dpm_power_modes_test;
  timeunit 1ns;
  timeprecision 100ps;

  logic                clk, rst_n, dcs, wr_n;
  logic [7:0]          cdata, reg_addr;
  logic [31:0]         reg_wdata, reg_rdata, rd;
  logic                reg_wr, reg_rd, load_defaults, settle_busy, busy_q;
  dpm_pkg::dpm_mode_t  mode;
  dpm_pkg::dpm_power_t power, pw_q;
  int                  n_mismatch = 0;
  int                  samples_checked = 0;
  int                  cyc = 0, n_load = 0, n_dist = 0;
  int                  t_load, t_conv, t_scan, t_show, t_idle;

  // Clock, 4 ns period
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  dpm_power_modes #(
    .SETTLE_CYC(200), .OSC_CYC(10), .CONV_CYC(10),
    .CHARGE_CYC(10), .FRAME_CYC(8)
  ) uut (
    .clk(clk), .rst_n(rst_n), .data_command_select(dcs),
    .write_strobe_n(wr_n), .cmd_data(cdata), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .mode(mode), .power(power),
    .load_defaults(load_defaults), .settle_busy(settle_busy)
  );

  dpm_host_model host (
    .clk(clk), .data_command_select(dcs), .write_strobe_n(wr_n),
    .cmd_data(cdata)
  );

  // Event times, all seen one edge late so differences stay exact
  always @(posedge clk) begin
    cyc    <= cyc + 1;
    pw_q   <= power;
    busy_q <= settle_busy;
    if (load_defaults === 1'b1) begin
      n_load <= n_load + 1;
      t_load <= cyc;
    end
    if (power.conv && !pw_q.conv) t_conv <= cyc;
    if (power.scan && !pw_q.scan) t_scan <= cyc;
    if (!power.blank && pw_q.blank) t_show <= cyc;
    if (!settle_busy && busy_q) t_idle <= cyc;
    // Any blanking or scan drop counts as a visible disturbance
    if ((power.blank && !pw_q.blank) || (!power.scan && pw_q.scan)) begin
      n_dist <= n_dist + 1;
    end
  end

  task automatic chk4(input string w, input logic [3:0] e,
                      input logic [3:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic chk32(input string w, input logic [31:0] e,
                       input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      n_mismatch++;
      $display("mismatch %s expected %h seen %h", w, e, g);
    end
  endtask

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic reg_read(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
    d = reg_rdata;
  endtask

  // Bounded wait for the settle window to close
  task automatic wait_idle();
    int n;
    n = 0;
    while (settle_busy !== 1'b0 && n < 400) begin
      @(posedge clk);
      n++;
    end
    if (n == 400) begin
      n_mismatch++;
      $display("mismatch settle_busy expected 0 seen 1");
    end
    @(posedge clk);
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // Watchdog, well past the sleep gap plus all wake windows
  initial begin
    repeat (30000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    rst_n     = 1'b0;
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 32'h0000_0000;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge clk);
    chk4("mode", dpm_pkg::MODE_RESET, mode);
    chk4("power", 4'h1, power);
    reg_read(dpm_pkg::ADDR_STATUS, rd);
    chk32("status", 32'h0000_0091, rd);
    reg_read(dpm_pkg::ADDR_DIAG, rd);
    chk32("diag", 32'h0000_0000, rd);
    reg_read(8'h0C, rd);
    chk32("unmapped", 32'h0000_0000, rd);
    $display("test reset done");
    // Commands while asleep, data and unknown bytes first
    host.send(8'h11, 1'b1);
    host.send(8'h20, 1'b0);
    chk4("mode", 4'h9, mode);
    host.send(dpm_pkg::OP_PARTIAL_ON, 1'b0);
    chk4("mode", 4'hC, mode);
    host.send(dpm_pkg::OP_PARTIAL_ON, 1'b0);
    chk4("mode", 4'hC, mode);
    host.send(dpm_pkg::OP_FULL_ON, 1'b0);
    chk4("mode", 4'h9, mode);
    host.send(dpm_pkg::OP_FULL_ON, 1'b0);
    chk4("mode", 4'h9, mode);
    reg_write(dpm_pkg::ADDR_CTRL, 32'h0000_0001);
    reg_read(dpm_pkg::ADDR_CTRL, rd);
    chk32("ctrl", 32'h0000_0001, rd);
    chk4("mode", 4'hA, mode);
    host.send(dpm_pkg::OP_FULL_ON, 1'b0);
    chk4("mode", 4'h9, mode);
    $display("test asleep done");
    // Wake from sleep and its timed sequence
    host.send(dpm_pkg::OP_WAKE, 1'b0);
    reg_read(dpm_pkg::ADDR_STATUS, rd);
    chk32("busy", 32'h1, 32'(rd[8]));
    wait_idle();
    chk32("osc_to_conv", 32'd10, 32'(t_conv - t_load));
    chk32("osc_to_scan", 32'd30, 32'(t_scan - t_load));
    chk32("blank_span", 32'd16, 32'(t_show - t_scan));
    chk32("settle", 32'd200, 32'(t_idle - t_load));
    chk32("loads", 32'd1, 32'(n_load));
    chk4("power", 4'hE, power);
    chk4("mode", 4'h1, mode);
    reg_read(dpm_pkg::ADDR_STATUS, rd);
    chk32("status", 32'h0000_001E, rd);
    reg_read(dpm_pkg::ADDR_DIAG, rd);
    chk32("diag", 32'h0000_00C0, rd);
    $display("test wake done");
    // Partial and normal while awake keep the device awake
    host.send(dpm_pkg::OP_PARTIAL_ON, 1'b0);
    chk4("mode", 4'h4, mode);
    host.send(dpm_pkg::OP_FULL_ON, 1'b0);
    chk4("mode", 4'h1, mode);
    chk4("power", 4'hE, power);
    // Second wake while awake, with a diagnostic fault injected
    reg_write(dpm_pkg::ADDR_CTRL, 32'h0000_0002);
    host.send(dpm_pkg::OP_WAKE, 1'b0);
    wait_idle();
    chk32("disturb", 32'd1, 32'(n_dist));
    chk32("loads", 32'd2, 32'(n_load));
    chk4("power", 4'hE, power);
    reg_read(dpm_pkg::ADDR_DIAG, rd);
    chk32("diag", 32'h0000_0041, rd);
    $display("test rewake done");
    // Sleep entry, then wake after the host gap
    host.send(dpm_pkg::OP_SLEEP_ENTRY, 1'b0);
    chk4("mode", 4'h9, mode);
    chk4("power", 4'h1, power);
    host.send(dpm_pkg::OP_WAKE, 1'b0);
    @(posedge clk);
    chk32("loads", 32'd3, 32'(n_load));
    chk4("mode", 4'h1, mode);
    $display("test sleep done");
    results();
  end
endmodule // dpm_power_modes_test
